/* File: hdl/dpbfm_cfg.svh */
// constants for the two-way queue and mailbox port controller:
// depths, pointer widths, flag offset presets and reset values.
// assumes it is included once per compilation unit by its bare name.
`ifndef DPBFM_CFG_SVH
`define DPBFM_CFG_SVH
`define DPBFM_DEPTH 7'h40
`define DPBFM_PTR_W 7
`define DPBFM_ADDR_W 6
`define DPBFM_OFFSET_0 7'h04
`define DPBFM_OFFSET_1 7'h08
`define DPBFM_OFFSET_2 7'h10
`define DPBFM_OFFSET_3 7'h20
`define DPBFM_FULL_PIPE_RST 2'b00
`define DPBFM_AFULL_PIPE_RST 2'b11
`define DPBFM_EMPTY_PIPE_RST 2'b00
`define DPBFM_AEMPTY_PIPE_RST 2'b00
`define DPBFM_MAIL_FLAG_RST 1'b1
`endif

/* File: hdl/dpbfm_pkg.sv */
// types shared by the two-way queue and mailbox port controller.
// assumes the constant header is compiled alongside.
package dpbfm_pkg;
  // one port's pins, after synchronisation
  typedef struct packed {
    logic port_clock;
    logic port_enable;
    logic select_n;
    logic write_not_read;
    logic mailbox_select;
    logic parity_generate;
    logic [35:0] data;
  } dpbfm_port_t;

  // the whole state of the controller apart from the queue storage
  typedef struct packed {
    dpbfm_port_t [1:0] sync1;
    dpbfm_port_t [1:0] sync2;
    logic [1:0] clk_prev;
    logic rstn_s1;
    logic rstn_s2;
    logic rstn_prev;
    logic [1:0] fs_s1;
    logic [1:0] fs_s2;
    logic [1:0] offset_sel;
    logic odd_s1;
    logic odd_s2;
    logic [1:0][6:0] wr_ptr;
    logic [1:0][6:0] rd_ptr;
    logic [1:0][1:0] full_pipe;
    logic [1:0][1:0] afull_pipe;
    logic [1:0][1:0] empty_pipe;
    logic [1:0][1:0] aempty_pipe;
    logic [1:0][35:0] fifo_out;
    logic [1:0][35:0] mailbox;
    logic [1:0][35:0] data_out;
    logic [1:0] mail_flag_n;
    logic [1:0] parity_error_n;
  } dpbfm_state_t;

  // parity bit for eight data bits; odd high means odd parity
  function automatic logic dpbfm_parity(input logic [7:0] b,
                                        input logic odd);
    dpbfm_parity = odd ? ~(^b) : (^b);
  endfunction
endpackage

/* File: hdl/dpbfm_top.sv */
// two opposed 64-word queues with mailbox bypass, parity check and
// generation, all on one system clock.
// assumes both port clocks are slow enough (under a quarter of I_CLK)
// to be sampled as plain inputs; every pin passes two flip-flops.
`timescale 1ns/10ps
`include "dpbfm_cfg.svh"
module dpbfm_top (
  // system
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // shared pins
  input wire logic I_RESET_N,
  input wire logic [1:0] I_OFFSET_SELECT,
  input wire logic I_ODD_PARITY,
  // port a pins
  input wire logic I_A_PORT_CLOCK,
  input wire logic I_A_PORT_ENABLE,
  input wire logic I_A_SELECT_N,
  input wire logic I_A_WRITE_NOT_READ,
  input wire logic I_A_MAILBOX_SELECT,
  input wire logic I_A_PARITY_GENERATE,
  input wire logic [35:0] I_A_DATA,
  output logic [35:0] O_A_DATA,
  output logic O_A_DATA_OE_N,
  // port b pins
  input wire logic I_B_PORT_CLOCK,
  input wire logic I_B_PORT_ENABLE,
  input wire logic I_B_SELECT_N,
  input wire logic I_B_WRITE_NOT_READ,
  input wire logic I_B_MAILBOX_SELECT,
  input wire logic I_B_PARITY_GENERATE,
  input wire logic [35:0] I_B_DATA,
  output logic [35:0] O_B_DATA,
  output logic O_B_DATA_OE_N,
  // port a flags
  output logic O_A_FULL_N,
  output logic O_A_ALMOST_FULL_N,
  output logic O_A_EMPTY_N,
  output logic O_A_ALMOST_EMPTY_N,
  output logic O_A_PARITY_ERROR_N,
  // port b flags
  output logic O_B_FULL_N,
  output logic O_B_ALMOST_FULL_N,
  output logic O_B_EMPTY_N,
  output logic O_B_ALMOST_EMPTY_N,
  output logic O_B_PARITY_ERROR_N,
  // mailbox flags
  output logic O_A_TO_B_MAIL_FLAG_N,
  output logic O_B_TO_A_MAIL_FLAG_N
);

  dpbfm_pkg::dpbfm_state_t state_reg; // registered state
  dpbfm_pkg::dpbfm_state_t state_next; // next state
  // queue storage; index 0 is a_to_b_queue, 1 is b_to_a_queue
  logic [35:0] a_to_b_queue [0:63];
  logic [35:0] b_to_a_queue [0:63];
  logic [1:0] mem_we; // write strobe per queue
  logic [1:0][5:0] mem_waddr; // write address per queue
  logic [1:0][35:0] mem_wdata; // write data per queue
  logic [35:0] head_a_to_b; // word at read pointer, a_to_b_queue
  logic [35:0] head_b_to_a; // word at read pointer, b_to_a_queue

  // pin capture packed into the port struct
  dpbfm_pkg::dpbfm_port_t [1:0] pins;
  assign pins[0] = {I_A_PORT_CLOCK, I_A_PORT_ENABLE, I_A_SELECT_N,
    I_A_WRITE_NOT_READ, I_A_MAILBOX_SELECT, I_A_PARITY_GENERATE, I_A_DATA};
  assign pins[1] = {I_B_PORT_CLOCK, I_B_PORT_ENABLE, I_B_SELECT_N,
    I_B_WRITE_NOT_READ, I_B_MAILBOX_SELECT, I_B_PARITY_GENERATE, I_B_DATA};

  assign head_a_to_b = a_to_b_queue[state_reg.rd_ptr[0][5:0]];
  assign head_b_to_a = b_to_a_queue[state_reg.rd_ptr[1][5:0]];

  // offset preset chosen by the latched select
  function automatic logic [6:0] offset_of(input logic [1:0] sel);
    case (sel)
      2'h0: offset_of = `DPBFM_OFFSET_0;
      2'h1: offset_of = `DPBFM_OFFSET_1;
      2'h2: offset_of = `DPBFM_OFFSET_2;
      default: offset_of = `DPBFM_OFFSET_3;
    endcase
  endfunction

  // next-state logic for both ports; port p writes queue p and reads 1-p
  always_comb begin
    logic [1:0] go_wr; // qualified write edge per port
    logic [1:0] go_rd; // qualified read edge per port
    logic [1:0][6:0] level; // stored words per queue
    logic [1:0] edge_hit; // rising edge of synced port clock
    logic [6:0] off; // active offset
    logic [35:0] src; // chosen output word
    logic bad; // any byte fails parity
    int o; // opposite port index
    go_wr = '0;
    go_rd = '0;
    level = '0;
    edge_hit = '0;
    off = offset_of(state_reg.offset_sel);
    src = '0;
    bad = 1'b0;
    o = 0;
    state_next = state_reg;
    mem_we = '0;
    mem_waddr = '0;
    mem_wdata = '0;
    // two-flop synchronisers; the first stage feeds only the second
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.rstn_s1 = I_RESET_N;
    state_next.rstn_s2 = state_reg.rstn_s1;
    state_next.rstn_prev = state_reg.rstn_s2;
    state_next.fs_s1 = I_OFFSET_SELECT;
    state_next.fs_s2 = state_reg.fs_s1;
    state_next.odd_s1 = I_ODD_PARITY;
    state_next.odd_s2 = state_reg.odd_s1;
    for (int p = 0; p < 2; p++) begin
      state_next.clk_prev[p] = state_reg.sync2[p].port_clock;
      edge_hit[p] = state_reg.sync2[p].port_clock & ~state_reg.clk_prev[p];
      // enable high and select low qualify the edge
      if (edge_hit[p] && state_reg.sync2[p].port_enable &&
          !state_reg.sync2[p].select_n) begin
        go_wr[p] = state_reg.sync2[p].write_not_read;
        go_rd[p] = ~state_reg.sync2[p].write_not_read;
      end
      level[p] = 7'(state_reg.wr_ptr[p] - state_reg.rd_ptr[p]);
    end
    for (int p = 0; p < 2; p++) begin
      o = 1 - p;
      if (go_wr[p] && !state_reg.sync2[p].mailbox_select) begin
        // the flag lags the level by two port edges, so the true level
        // also gates the write and an early write cannot overrun
        if (state_reg.full_pipe[p][1] &&
            level[p] != `DPBFM_DEPTH) begin
          mem_we[p] = 1'b1;
          mem_waddr[p] = state_reg.wr_ptr[p][5:0];
          mem_wdata[p] = state_reg.sync2[p].data;
          state_next.wr_ptr[p] = 7'(state_reg.wr_ptr[p] + 7'h01);
        end
      end
      if (go_wr[p] && state_reg.sync2[p].mailbox_select) begin
        // a pending mail blocks overwrite until it is read
        if (state_reg.mail_flag_n[p]) begin
          state_next.mailbox[p] = state_reg.sync2[p].data;
          state_next.mail_flag_n[p] = 1'b0;
        end
      end
      if (go_rd[p] && !state_reg.sync2[p].mailbox_select) begin
        // reads from an empty queue leave pointer and output alone
        if (state_reg.empty_pipe[p][1] && level[o] != 7'h00) begin
          state_next.fifo_out[p] = (p == 0) ? head_b_to_a : head_a_to_b;
          state_next.rd_ptr[o] = 7'(state_reg.rd_ptr[o] + 7'h01);
        end
      end
      // a new mail in the same cycle as the read wins and keeps the flag low, but it is dropped if a mail was already pending
      if (go_rd[p] && state_reg.sync2[p].mailbox_select &&
          !(go_wr[o] && state_reg.sync2[o].mailbox_select)) begin
        state_next.mail_flag_n[o] = 1'b1;
      end
      // flags step through two stages on the owning port's edges
      if (edge_hit[p]) begin
        state_next.full_pipe[p] = {state_reg.full_pipe[p][0],
          level[p] != `DPBFM_DEPTH};
        state_next.afull_pipe[p] = {state_reg.afull_pipe[p][0],
          7'(`DPBFM_DEPTH - level[p]) > off};
        state_next.empty_pipe[p] = {state_reg.empty_pipe[p][0],
          level[o] != 7'h00};
        state_next.aempty_pipe[p] = {state_reg.aempty_pipe[p][0],
          level[o] > off};
      end
      // output source follows mailbox select
      src = state_reg.sync2[p].mailbox_select ? state_reg.mailbox[o]
                                               : state_reg.fifo_out[p];
      bad = 1'b0;
      for (int k = 0; k < 4; k++) begin
        if (state_reg.sync2[p].parity_generate) begin
          src[9*k+8] = dpbfm_pkg::dpbfm_parity(src[9*k +: 8],
                                               state_reg.odd_s2);
        end
        // odd parity passes when the nine bits hold an odd count
        if ((^state_reg.sync2[p].data[9*k +: 9]) != state_reg.odd_s2) begin
          bad = 1'b1;
        end
      end
      state_next.data_out[p] = src;
      // shared trees: a generated mailbox read hides the check
      if (!state_reg.sync2[p].write_not_read &&
          state_reg.sync2[p].mailbox_select &&
          state_reg.sync2[p].parity_generate) begin
        state_next.parity_error_n[p] = 1'b1;
      end else begin
        state_next.parity_error_n[p] = ~bad;
      end
    end
    // offset select is caught as the reset pin rises
    if (state_reg.rstn_s2 && !state_reg.rstn_prev) begin
      state_next.offset_sel = state_reg.fs_s2;
    end
    // device reset pin clears pointers and presets the queue and mail flags
    if (!state_reg.rstn_s2) begin
      mem_we = '0;
      state_next.wr_ptr = '0;
      state_next.rd_ptr = '0;
      state_next.mail_flag_n = {2{`DPBFM_MAIL_FLAG_RST}};
      state_next.full_pipe = {2{`DPBFM_FULL_PIPE_RST}};
      state_next.afull_pipe = {2{`DPBFM_AFULL_PIPE_RST}};
      state_next.empty_pipe = {2{`DPBFM_EMPTY_PIPE_RST}};
      state_next.aempty_pipe = {2{`DPBFM_AEMPTY_PIPE_RST}};
    end
  end

  // state register; system reset behaves like the pin held low
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_reg <= '0;
      state_reg.mail_flag_n <= {2{`DPBFM_MAIL_FLAG_RST}};
      state_reg.afull_pipe <= {2{`DPBFM_AFULL_PIPE_RST}};
      state_reg.parity_error_n <= 2'b11;
      state_reg.sync1[0].select_n <= 1'b1;
      state_reg.sync1[1].select_n <= 1'b1;
      state_reg.sync2[0].select_n <= 1'b1;
      state_reg.sync2[1].select_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // queue storage writes; no reset, contents are don't-care when empty
  always_ff @(posedge I_CLK) begin
    if (mem_we[0]) begin
      a_to_b_queue[mem_waddr[0]] <= mem_wdata[0];
    end
    if (mem_we[1]) begin
      b_to_a_queue[mem_waddr[1]] <= mem_wdata[1];
    end
  end

  // data pins driven only for a selected read
  assign O_A_DATA_OE_N = state_reg.sync2[0].write_not_read |
                         state_reg.sync2[0].select_n;
  assign O_B_DATA_OE_N = state_reg.sync2[1].write_not_read |
                         state_reg.sync2[1].select_n;
  assign O_A_DATA = state_reg.data_out[0];
  assign O_B_DATA = state_reg.data_out[1];
  // queue flag outputs straight from the second stage; parity and mail flags from their registers
  assign O_A_FULL_N = state_reg.full_pipe[0][1];
  assign O_B_FULL_N = state_reg.full_pipe[1][1];
  assign O_A_ALMOST_FULL_N = state_reg.afull_pipe[0][1];
  assign O_B_ALMOST_FULL_N = state_reg.afull_pipe[1][1];
  assign O_A_EMPTY_N = state_reg.empty_pipe[0][1];
  assign O_B_EMPTY_N = state_reg.empty_pipe[1][1];
  assign O_A_ALMOST_EMPTY_N = state_reg.aempty_pipe[0][1];
  assign O_B_ALMOST_EMPTY_N = state_reg.aempty_pipe[1][1];
  assign O_A_PARITY_ERROR_N = state_reg.parity_error_n[0];
  assign O_B_PARITY_ERROR_N = state_reg.parity_error_n[1];
  assign O_A_TO_B_MAIL_FLAG_N = state_reg.mail_flag_n[0];
  assign O_B_TO_A_MAIL_FLAG_N = state_reg.mail_flag_n[1];

endmodule // dpbfm_top

/* File: verification/dpbfm_top_props.sv */
// assertion checker for the two-way queue controller, bound to its top.
// assumes every transfer holds its controls for several system clocks.
`timescale 1ns/10ps
module dpbfm_top_props (
  // system clock, system reset and device reset pin
  input wire logic I_CLK, I_SYS_RST, I_RESET_N,
  // port controls
  input wire logic I_A_SELECT_N, I_A_WRITE_NOT_READ, I_A_MAILBOX_SELECT,
  input wire logic I_A_PARITY_GENERATE, I_B_SELECT_N, I_B_WRITE_NOT_READ,
  input wire logic I_B_MAILBOX_SELECT, I_B_PARITY_GENERATE,
  // watched outputs
  input wire logic O_A_DATA_OE_N, O_B_DATA_OE_N, O_A_PARITY_ERROR_N,
  input wire logic O_B_PARITY_ERROR_N, O_A_TO_B_MAIL_FLAG_N,
  input wire logic O_B_TO_A_MAIL_FLAG_N
);
  // the reset pin restarts every queue and mail flag, so it mutes the checks too
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST || !I_RESET_N);

  a_oe_a_off: assert property (
    (I_A_WRITE_NOT_READ || I_A_SELECT_N)[*4] |=> O_A_DATA_OE_N)
    else $error("port a bus driven outside a read");
  a_oe_b_off: assert property (
    (I_B_WRITE_NOT_READ || I_B_SELECT_N)[*4] |=> O_B_DATA_OE_N)
    else $error("port b bus driven outside a read");
  // a flag may only move three clocks after the matching access
  a_mail_ab_set: assert property (
    $fell(O_A_TO_B_MAIL_FLAG_N) |->
    $past(I_A_MAILBOX_SELECT, 3) && $past(I_A_WRITE_NOT_READ, 3))
    else $error("a to b mail flag fell without a write");
  a_mail_ab_clear: assert property (
    $rose(O_A_TO_B_MAIL_FLAG_N) |->
    $past(I_B_MAILBOX_SELECT, 3) && !$past(I_B_WRITE_NOT_READ, 3))
    else $error("a to b mail flag rose without a read");
  a_mail_ba_set: assert property (
    $fell(O_B_TO_A_MAIL_FLAG_N) |->
    $past(I_B_MAILBOX_SELECT, 3) && $past(I_B_WRITE_NOT_READ, 3))
    else $error("b to a mail flag fell without a write");
  a_mail_ba_clear: assert property (
    $rose(O_B_TO_A_MAIL_FLAG_N) |->
    $past(I_A_MAILBOX_SELECT, 3) && !$past(I_A_WRITE_NOT_READ, 3))
    else $error("b to a mail flag rose without a read");
  a_perr_gen_a: assert property (
    (!I_A_WRITE_NOT_READ && I_A_MAILBOX_SELECT && I_A_PARITY_GENERATE
    && !I_A_SELECT_N)[*4] |=> O_A_PARITY_ERROR_N)
    else $error("port a parity error during mail generation");
  a_perr_gen_b: assert property (
    (!I_B_WRITE_NOT_READ && I_B_MAILBOX_SELECT && I_B_PARITY_GENERATE
    && !I_B_SELECT_N)[*4] |=> O_B_PARITY_ERROR_N)
    else $error("port b parity error during mail generation");
endmodule // dpbfm_top_props

bind dpbfm_top dpbfm_top_props i_props (
  .I_CLK, .I_SYS_RST, .I_RESET_N, .I_A_SELECT_N, .I_A_WRITE_NOT_READ,
  .I_A_MAILBOX_SELECT, .I_A_PARITY_GENERATE, .I_B_SELECT_N,
  .I_B_WRITE_NOT_READ, .I_B_MAILBOX_SELECT, .I_B_PARITY_GENERATE,
  .O_A_DATA_OE_N, .O_B_DATA_OE_N, .O_A_PARITY_ERROR_N, .O_B_PARITY_ERROR_N,
  .O_A_TO_B_MAIL_FLAG_N, .O_B_TO_A_MAIL_FLAG_N
);

/* File: verification/dpbfm_port_master.sv */
// model of a synchronous bus master on one port: a free-running port
// clock at an eighth of the system clock and a one-edge transfer task.
// assumes the bench calls xfer from one process at a time.
`timescale 1ns/10ps
module dpbfm_port_master (
  // system clock that paces the model
  input wire logic clk,
  // port pins into the device
  output logic pclk, en, cs_n, wnr, mb, pg,
  output logic [35:0] dq
);
  logic [2:0] ph = 3'h0; // phase; the port clock is its top bit
  assign pclk = ph[2];
  // port clock runs continuously, as the device expects
  always @(posedge clk) ph <= ph + 3'h1;
  initial begin
    en = 1'b0;
    cs_n = 1'b1;
    wnr = 1'b1;
    mb = 1'b0;
    pg = 1'b0;
    dq = 36'h0_0000_0000;
  end
  // controls change while the port clock is low and stand through the
  // edge and the device's sampling delay; the released bus shows the
  // inverse, so a stale word cannot pass for a fresh one
  task automatic xfer(input logic w, m, g, input logic [35:0] d);
    do @(posedge clk); while (ph != 3'h7);
    en <= 1'b1;
    cs_n <= 1'b0;
    wnr <= w;
    mb <= m;
    pg <= g;
    dq <= d;
    repeat (8) @(posedge clk);
    en <= 1'b0;
    cs_n <= 1'b1;
    dq <= ~d;
  endtask
endmodule // dpbfm_port_master

/* File: verification/dual_port_bidir_fifo_mailbox_test.sv */
// self-checking bench for the two-way queue and mailbox controller.
// assumes the design header, package and checker are compiled first.
`timescale 1ns/10ps
module dual_port_bidir_fifo_mailbox_test;
  localparam logic [35:0] ZERO = 36'h0_0000_0000;
  localparam logic [35:0] MAIL = 36'h9_1234_5678; // mixed parity bits
  // system and shared pins
  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_RESET_N = 1'b0;
  logic [1:0] I_OFFSET_SELECT = 2'h1; // offset preset of eight words
  logic I_ODD_PARITY = 1'b0;
  // port pins, driven by the two master models
  logic I_A_PORT_CLOCK, I_A_PORT_ENABLE, I_A_SELECT_N, I_A_WRITE_NOT_READ;
  logic I_A_MAILBOX_SELECT, I_A_PARITY_GENERATE, I_B_PORT_CLOCK;
  logic I_B_PORT_ENABLE, I_B_SELECT_N, I_B_WRITE_NOT_READ;
  logic I_B_MAILBOX_SELECT, I_B_PARITY_GENERATE;
  logic [35:0] I_A_DATA, I_B_DATA, O_A_DATA, O_B_DATA;
  // outputs and flags
  logic O_A_DATA_OE_N, O_B_DATA_OE_N, O_A_FULL_N, O_A_ALMOST_FULL_N;
  logic O_A_EMPTY_N, O_A_ALMOST_EMPTY_N, O_A_PARITY_ERROR_N, O_B_FULL_N;
  logic O_B_ALMOST_FULL_N, O_B_EMPTY_N, O_B_ALMOST_EMPTY_N;
  logic O_B_PARITY_ERROR_N, O_A_TO_B_MAIL_FLAG_N, O_B_TO_A_MAIL_FLAG_N;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 I_CLK = ~I_CLK;

  dpbfm_top i_dut (.I_CLK, .I_SYS_RST, .I_RESET_N, .I_OFFSET_SELECT,
    .I_ODD_PARITY, .I_A_PORT_CLOCK, .I_A_PORT_ENABLE, .I_A_SELECT_N,
    .I_A_WRITE_NOT_READ, .I_A_MAILBOX_SELECT, .I_A_PARITY_GENERATE,
    .I_A_DATA, .O_A_DATA, .O_A_DATA_OE_N, .I_B_PORT_CLOCK,
    .I_B_PORT_ENABLE, .I_B_SELECT_N, .I_B_WRITE_NOT_READ,
    .I_B_MAILBOX_SELECT, .I_B_PARITY_GENERATE, .I_B_DATA, .O_B_DATA,
    .O_B_DATA_OE_N, .O_A_FULL_N, .O_A_ALMOST_FULL_N, .O_A_EMPTY_N,
    .O_A_ALMOST_EMPTY_N, .O_A_PARITY_ERROR_N, .O_B_FULL_N,
    .O_B_ALMOST_FULL_N, .O_B_EMPTY_N, .O_B_ALMOST_EMPTY_N,
    .O_B_PARITY_ERROR_N, .O_A_TO_B_MAIL_FLAG_N, .O_B_TO_A_MAIL_FLAG_N);
  dpbfm_port_master i_pa (.clk(I_CLK), .pclk(I_A_PORT_CLOCK),
    .en(I_A_PORT_ENABLE), .cs_n(I_A_SELECT_N), .wnr(I_A_WRITE_NOT_READ),
    .mb(I_A_MAILBOX_SELECT), .pg(I_A_PARITY_GENERATE), .dq(I_A_DATA));
  dpbfm_port_master i_pb (.clk(I_CLK), .pclk(I_B_PORT_CLOCK),
    .en(I_B_PORT_ENABLE), .cs_n(I_B_SELECT_N), .wnr(I_B_WRITE_NOT_READ),
    .mb(I_B_MAILBOX_SELECT), .pg(I_B_PARITY_GENERATE), .dq(I_B_DATA));

  // distinct queue word for each index below 512
  function automatic logic [35:0] wd(input int k);
    wd = {k[8:0], ~k[8:0], k[8:0], ~k[8:0]};
  endfunction
  // word with its four byte tops replaced by fresh parity
  function automatic logic [35:0] gen(input logic [35:0] d, input logic p);
    gen = d;
    for (int i = 0; i < 4; i++) gen[9 * i + 8] = p ^ (^d[9 * i +: 8]);
  endfunction
  task automatic check(input logic [35:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard: the whole run needs about 2400 system clocks
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 9000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    repeat (40) @(posedge I_CLK); // five edges of each port clock
    check(O_A_FULL_N, 1'b0);
    I_RESET_N <= 1'b1;
    repeat (30) @(posedge I_CLK);
    check({O_A_FULL_N, O_B_FULL_N}, 2'h3);
    check({O_A_EMPTY_N, O_B_EMPTY_N, O_A_ALMOST_EMPTY_N}, 3'h0);
    check({O_A_ALMOST_FULL_N, O_B_TO_A_MAIL_FLAG_N}, 2'h3);
    check({O_A_DATA_OE_N, O_B_DATA_OE_N, O_B_ALMOST_FULL_N}, 3'h7);
    check(O_B_PARITY_ERROR_N, 1'b1);
    $display("reset test ends");
    // the last write meets a full queue and must vanish
    for (int k = 0; k < 65; k++) i_pa.xfer(1'b1, 1'b0, 1'b0, wd(k));
    repeat (40) @(posedge I_CLK);
    check({O_A_FULL_N, O_A_ALMOST_FULL_N, O_B_ALMOST_EMPTY_N}, 3'h1);
    check(O_B_EMPTY_N, 1'b1);
    $display("queue fill test ends");
    // the last read meets an empty queue and leaves the old word
    for (int k = 0; k < 65; k++) begin
      i_pb.xfer(1'b0, 1'b0, 1'b0, ZERO);
      repeat (2) @(posedge I_CLK);
      check(O_B_DATA, wd(k < 64 ? k : 63));
      if (k == 53 || k == 57) check(O_B_ALMOST_EMPTY_N, k == 53);
    end
    repeat (40) @(posedge I_CLK);
    check({O_B_EMPTY_N, O_B_ALMOST_EMPTY_N, O_A_FULL_N}, 3'h1);
    $display("queue drain test ends");
    check(O_A_TO_B_MAIL_FLAG_N, 1'b1);
    i_pa.xfer(1'b1, 1'b1, 1'b0, MAIL);
    repeat (2) @(posedge I_CLK);
    check(O_A_TO_B_MAIL_FLAG_N, 1'b0);
    i_pa.xfer(1'b1, 1'b1, 1'b0, ZERO);
    i_pb.xfer(1'b0, 1'b1, 1'b1, ZERO);
    repeat (2) @(posedge I_CLK);
    check(O_B_DATA, gen(MAIL, 1'b0));
    check(O_A_TO_B_MAIL_FLAG_N, 1'b1);
    for (int p = 0; p < 2; p++) begin
      I_ODD_PARITY <= p[0];
      i_pb.xfer(1'b1, 1'b1, 1'b0, MAIL);
      i_pa.xfer(1'b0, 1'b1, 1'b1, ZERO);
      repeat (2) @(posedge I_CLK);
      check(O_A_DATA, gen(MAIL, p[0]));
      check({O_B_TO_A_MAIL_FLAG_N, O_B_EMPTY_N}, 2'h2);
    end
    $display("mailbox test ends");
    // one wrong parity bit per byte in turn, then a clean bus
    I_ODD_PARITY <= 1'b0;
    i_pa.pg <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      i_pa.dq <= 36'h0_0000_0100 << (9 * i);
      repeat (6) @(posedge I_CLK);
      check(O_A_PARITY_ERROR_N, i == 4);
    end
    I_ODD_PARITY <= 1'b1;
    repeat (6) @(posedge I_CLK);
    check(O_A_PARITY_ERROR_N, 1'b0);
    $display("parity check test ends");
    test_done();
  end
endmodule // dual_port_bidir_fifo_mailbox_test
